//--- core/ppaoc_pkg.sv
// package with widths, register offsets and reset values for the port configuration block
`default_nettype none
package ppaoc_pkg;
   localparam int PORT_WIDTH = 16;
   localparam int ADDR_WIDTH = 3;
   // register offsets
   localparam logic [2:0] ADDR_DIRECTION = 3'h0;
   localparam logic [2:0] ADDR_PIN_LEVEL = 3'h1;
   localparam logic [2:0] ADDR_OUT_LATCH = 3'h2;
   localparam logic [2:0] ADDR_OPEN_DRAIN = 3'h3;
   localparam logic [2:0] ADDR_ANALOG_SEL = 3'h4;
   // reset values
   localparam logic [15:0] RST_DIRECTION = 16'hffff;
   localparam logic [15:0] RST_OUT_LATCH = 16'h0000;
   localparam logic [15:0] RST_OPEN_DRAIN = 16'h0000;
   localparam logic [15:0] RST_ANALOG_SEL = 16'hffff;
   localparam logic [15:0] READ_UNMAPPED = 16'h0000;
endpackage
`default_nettype wire

//--- core/ppaoc_pin_cell.sv
// one pin: driver, input sampling and analog/digital steering
`default_nettype none
module ppaoc_pin_cell (
   input wire logic i_sys_clk,
   input wire logic i_rst_n,
   input wire logic i_dir,
   input wire logic i_latch,
   input wire logic i_open_drain,
   input wire logic i_analog,
   input wire logic i_pin,
   input wire logic i_periph_out,
   input wire logic i_periph_en,
   output logic o_pin,
   output logic o_pin_oe_n,
   output logic o_level,
   output logic o_periph_in,
   output logic o_analog_en
);
   logic sync1_reg;
   logic sync2_reg;
   logic drive_val;
   logic is_output;

   // two-stage synchroniser; first stage read only by the second
   always_ff @(posedge i_sys_clk) begin
      if (!i_rst_n) begin
         sync1_reg <= 1'b0;
         sync2_reg <= 1'b0;
      end else begin
         sync1_reg <= i_pin;
         sync2_reg <= sync1_reg;
      end
   end

   // digital peripheral may take over only a digital pin
   assign drive_val = (i_periph_en && !i_analog) ? i_periph_out : i_latch;
   // output still driven when analog is selected with direction cleared
   assign is_output = !i_dir;
   // open drain drives low only and releases for a high level
   assign o_pin = i_open_drain ? 1'b0 : drive_val;
   assign o_pin_oe_n = !(is_output && (!i_open_drain || !drive_val));
   // analog inputs read as zero, hiding a floating level
   assign o_level = (i_analog && i_dir) ? 1'b0 : sync2_reg;
   assign o_periph_in = i_analog ? 1'b0 : sync2_reg;
   // converter path only for analog-selected pins, digital inputs never feed it
   assign o_analog_en = i_analog;

   a_od_release: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
      (i_open_drain && drive_val) |-> o_pin_oe_n)
      else $error("open drain pin driven high");
   a_od_low: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
      (i_open_drain && !i_dir && !drive_val) |-> (!o_pin_oe_n && !o_pin))
      else $error("open drain low not driven");
   a_analog_zero: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
      (i_analog && i_dir) |-> !o_level)
      else $error("analog input read nonzero");
   a_periph_block: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
      i_analog |-> !o_periph_in)
      else $error("analog pin reached peripheral");
   a_digital_no_adc: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
      !i_analog |-> !o_analog_en)
      else $error("digital pin fed converter");
   a_analog_drive: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
      (i_analog && !i_dir && !i_open_drain) |-> (!o_pin_oe_n && o_pin == i_latch))
      else $error("analog output pin not driven");
endmodule
`default_nettype wire

//--- core/ppaoc_port.sv
// port configuration top: registers, read mux and per-pin cells
// Overview of operation
// - each pin has an open-drain select bit turning its driver open drain
// - converter path needs only the analog-select bit, direction does not gate it
// - digital peripherals reach a pin only when its analog-select is clear
// - analog-select register resets to all ones
// - direction clear means output, still driven when analog-selected
// - reading pin levels returns zero for analog inputs
// - digital inputs never feed the converter path
`default_nettype none
module ppaoc_port
   import ppaoc_pkg::*;
#(
   parameter int WIDTH = ppaoc_pkg::PORT_WIDTH
) (
   input wire logic i_sys_clk,
   input wire logic i_rst_n,
   input wire logic [ppaoc_pkg::ADDR_WIDTH-1:0] i_addr,
   input wire logic [WIDTH-1:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   output logic [WIDTH-1:0] o_rdata,
   input wire logic [WIDTH-1:0] i_pin,
   output logic [WIDTH-1:0] o_pin,
   output logic [WIDTH-1:0] o_pin_oe_n,
   input wire logic [WIDTH-1:0] i_periph_out,
   input wire logic [WIDTH-1:0] i_periph_en,
   output logic [WIDTH-1:0] o_periph_in,
   output logic [WIDTH-1:0] o_analog_en
);
   import ppaoc_pkg::*;

   // register map, one 16-bit word per offset, one bit per pin:
   //    0 direction, a set bit makes the pin an input
   //    1 pin level, reads the sampled pins, a write lands in the latch
   //    2 output latch
   //    3 open-drain select
   //    4 analog select
   //    5 to 7 unused, read zero and ignore writes
   // timing seen by software:
   //    a write takes effect at the edge that samples its strobe
   //    read data stand in the one cycle after the read strobe, zero otherwise
   //    a pin change reaches a read only after the two synchroniser stages

   logic [WIDTH-1:0] pin_direction_control_reg;
   logic [WIDTH-1:0] output_latch_value_reg;
   logic [WIDTH-1:0] open_drain_select_reg;
   logic [WIDTH-1:0] analog_pin_select_reg;
   logic [WIDTH-1:0] pin_level_value;
   logic [WIDTH-1:0] rdata_next;
   logic [WIDTH-1:0] rdata_reg;

   // direction register, all inputs after reset so nothing drives early
   always_ff @(posedge i_sys_clk) begin
      if (!i_rst_n) begin
         pin_direction_control_reg <= WIDTH'(RST_DIRECTION);
      end else if (i_wr && i_addr == ADDR_DIRECTION) begin
         pin_direction_control_reg <= i_wdata;
      end
   end

   // output latch; a write to the pin level offset also lands here
   always_ff @(posedge i_sys_clk) begin
      if (!i_rst_n) begin
         output_latch_value_reg <= WIDTH'(RST_OUT_LATCH);
      end else if (i_wr && (i_addr == ADDR_OUT_LATCH || i_addr == ADDR_PIN_LEVEL)) begin
         output_latch_value_reg <= i_wdata;
      end
   end

   // open-drain select
   always_ff @(posedge i_sys_clk) begin
      if (!i_rst_n) begin
         open_drain_select_reg <= WIDTH'(RST_OPEN_DRAIN);
      end else if (i_wr && i_addr == ADDR_OPEN_DRAIN) begin
         open_drain_select_reg <= i_wdata;
      end
   end

   // analog select comes up all analog to keep digital buffers off floating inputs
   always_ff @(posedge i_sys_clk) begin
      if (!i_rst_n) begin
         analog_pin_select_reg <= WIDTH'(RST_ANALOG_SEL);
      end else if (i_wr && i_addr == ADDR_ANALOG_SEL) begin
         analog_pin_select_reg <= i_wdata;
      end
   end

   // read mux; unmapped offsets read zero
   always_comb begin
      rdata_next = WIDTH'(READ_UNMAPPED);
      case (i_addr)
         ADDR_DIRECTION: rdata_next = pin_direction_control_reg;
         ADDR_PIN_LEVEL: rdata_next = pin_level_value;
         ADDR_OUT_LATCH: rdata_next = output_latch_value_reg;
         ADDR_OPEN_DRAIN: rdata_next = open_drain_select_reg;
         ADDR_ANALOG_SEL: rdata_next = analog_pin_select_reg;
         default: rdata_next = WIDTH'(READ_UNMAPPED);
      endcase
   end

   // read data held only in the cycle after the strobe
   always_ff @(posedge i_sys_clk) begin
      if (!i_rst_n) begin
         rdata_reg <= '0;
      end else if (i_rd) begin
         rdata_reg <= rdata_next;
      end else begin
         rdata_reg <= '0;
      end
   end
   assign o_rdata = rdata_reg;

   // the pin synchroniser adds two cycles; software must leave a gap
   genvar gi;
   generate
      for (gi = 0; gi < WIDTH; gi++) begin : g_pin
         ppaoc_pin_cell u_cell (
            .i_sys_clk(i_sys_clk),
            .i_rst_n(i_rst_n),
            .i_dir(pin_direction_control_reg[gi]),
            .i_latch(output_latch_value_reg[gi]),
            .i_open_drain(open_drain_select_reg[gi]),
            .i_analog(analog_pin_select_reg[gi]),
            .i_pin(i_pin[gi]),
            .i_periph_out(i_periph_out[gi]),
            .i_periph_en(i_periph_en[gi]),
            .o_pin(o_pin[gi]),
            .o_pin_oe_n(o_pin_oe_n[gi]),
            .o_level(pin_level_value[gi]),
            .o_periph_in(o_periph_in[gi]),
            .o_analog_en(o_analog_en[gi])
         );
      end
   endgenerate

   // reset values: pins come up as undriven analog inputs with the bus quiet
   a_analog_reset: assert property (@(posedge i_sys_clk)
      !i_rst_n |=> (analog_pin_select_reg == WIDTH'(RST_ANALOG_SEL)))
      else $error("analog select not all ones after reset");
   a_dir_reset: assert property (@(posedge i_sys_clk)
      !i_rst_n |=> (pin_direction_control_reg == WIDTH'(RST_DIRECTION)))
      else $error("direction not all inputs after reset");
   a_latch_reset: assert property (@(posedge i_sys_clk)
      !i_rst_n |=> (output_latch_value_reg == WIDTH'(RST_OUT_LATCH)))
      else $error("output latch not cleared by reset");
   a_od_reset: assert property (@(posedge i_sys_clk)
      !i_rst_n |=> (open_drain_select_reg == WIDTH'(RST_OPEN_DRAIN)))
      else $error("open drain select not cleared by reset");
   a_rdata_reset: assert property (@(posedge i_sys_clk)
      !i_rst_n |=> (o_rdata == '0))
      else $error("read data not cleared by reset");

   // writes: each offset updates only its own register, the pin level offset the output latch, at the strobe edge
   a_dir_write: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
      (i_wr && i_addr == ADDR_DIRECTION) |=> (pin_direction_control_reg == $past(i_wdata)))
      else $error("direction write lost");
   a_latch_write: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
      (i_wr && (i_addr == ADDR_OUT_LATCH || i_addr == ADDR_PIN_LEVEL)) |=>
      (output_latch_value_reg == $past(i_wdata)))
      else $error("output latch write lost");
   a_od_write: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
      (i_wr && i_addr == ADDR_OPEN_DRAIN) |=> (open_drain_select_reg == $past(i_wdata)))
      else $error("open drain write lost");
   a_analog_write: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
      (i_wr && i_addr == ADDR_ANALOG_SEL) |=> (analog_pin_select_reg == $past(i_wdata)))
      else $error("analog select write lost");
   // a stray write to an unused offset must not reconfigure any pin
   a_unmapped_write: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
      (i_wr && i_addr > ADDR_ANALOG_SEL) |=>
      ($stable(pin_direction_control_reg) && $stable(output_latch_value_reg) &&
      $stable(open_drain_select_reg) && $stable(analog_pin_select_reg)))
      else $error("unused offset write changed a register");

   // reads: data of the addressed register, one cycle after the strobe
   a_read_dir: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
      (i_rd && i_addr == ADDR_DIRECTION) |=> (o_rdata == $past(pin_direction_control_reg)))
      else $error("direction read wrong");
   a_read_latch: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
      (i_rd && i_addr == ADDR_OUT_LATCH) |=> (o_rdata == $past(output_latch_value_reg)))
      else $error("output latch read wrong");
   a_read_od: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
      (i_rd && i_addr == ADDR_OPEN_DRAIN) |=> (o_rdata == $past(open_drain_select_reg)))
      else $error("open drain read wrong");
   a_read_analog: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
      (i_rd && i_addr == ADDR_ANALOG_SEL) |=> (o_rdata == $past(analog_pin_select_reg)))
      else $error("analog select read wrong");
   a_read_zero: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
      (i_rd && i_addr == ADDR_PIN_LEVEL) |=>
      ((o_rdata & $past(analog_pin_select_reg & pin_direction_control_reg)) == '0))
      else $error("analog input bits read nonzero");
   a_read_unmapped: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
      (i_rd && i_addr > ADDR_ANALOG_SEL) |=> (o_rdata == '0))
      else $error("unused offset read nonzero");
   // a stale word left on the bus would be taken for a fresh read
   a_read_once: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
      !i_rd |=> (o_rdata == '0))
      else $error("read data outside its cycle");

   // pin drive summary across the whole port
   a_input_undriven: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
      (pin_direction_control_reg & ~o_pin_oe_n) == '0)
      else $error("input pin driven");
   a_od_no_high: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
      (open_drain_select_reg & ~o_pin_oe_n & o_pin) == '0)
      else $error("port drives a high on an open drain pin");
   a_od_low_drive: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
      (open_drain_select_reg & ~pin_direction_control_reg & ~i_periph_en &
      ~output_latch_value_reg & o_pin_oe_n) == '0)
      else $error("open drain output low not driven");
   // peripherals see only digital pins and drive only digital pins
   a_analog_periph: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
      (analog_pin_select_reg & o_periph_in) == '0)
      else $error("analog pin level reached a peripheral");
   a_periph_digital: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
      (~analog_pin_select_reg & ~pin_direction_control_reg & ~open_drain_select_reg &
      i_periph_en & (o_pin_oe_n | (o_pin ^ i_periph_out))) == '0)
      else $error("peripheral drive not on digital pin");
   a_analog_out_drive: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
      (analog_pin_select_reg & ~pin_direction_control_reg & ~open_drain_select_reg &
      (o_pin_oe_n | (o_pin ^ output_latch_value_reg))) == '0)
      else $error("analog output pin lost its latch level");
   a_adc_digital: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
      (o_analog_en & ~analog_pin_select_reg) == '0)
      else $error("digital pin routed to converter");
endmodule
`default_nettype wire

//--- tb/ppaoc_pin_model.sv
// pin-side model: outside drivers and a pull-up on every pin
`default_nettype none
module ppaoc_pin_model (
   input wire logic [15:0] i_pin_out,
   input wire logic [15:0] i_oe_n,
   input wire logic [15:0] i_ext_en,
   input wire logic [15:0] i_ext_val,
   output logic [15:0] o_level
);
   timeunit 1ns;
   timeprecision 1ps;
   // a released pin with no outside driver floats to the pull-up, never holds its last value
   assign o_level = (~i_oe_n & i_pin_out) | (i_oe_n & (~i_ext_en | i_ext_val));
endmodule
`default_nettype wire

//--- tb/tb.sv
// self-checking bench for the port configuration block
`default_nettype none
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   import ppaoc_pkg::*;
   logic i_sys_clk = 1'b0, i_rst_n = 1'b0, i_wr = 1'b0, i_rd = 1'b0;
   logic [2:0] i_addr = 3'h0;
   logic [15:0] i_wdata = 16'h0000, ext_en = 16'h0000, ext_val = 16'h0000;
   logic [15:0] i_periph_out = 16'h0000, i_periph_en = 16'h0000;
   logic [15:0] o_rdata, i_pin, o_pin, o_pin_oe_n, o_periph_in, o_analog_en;
   int bad_count = 0, checks = 0;
   ppaoc_port DUT (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_addr(i_addr),
      .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_pin(i_pin),
      .o_pin(o_pin), .o_pin_oe_n(o_pin_oe_n), .i_periph_out(i_periph_out),
      .i_periph_en(i_periph_en), .o_periph_in(o_periph_in), .o_analog_en(o_analog_en));
   ppaoc_pin_model PINS (.i_pin_out(o_pin), .i_oe_n(o_pin_oe_n), .i_ext_en(ext_en),
      .i_ext_val(ext_val), .o_level(i_pin));
   // 40 MHz clock
   always #12.5 i_sys_clk = ~i_sys_clk;
   task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
      checks++;
      if (got !== exp) begin
         bad_count++;
         $display("[ERR] %s expected %h seen %h", nm, exp, got);
      end
   endtask
   // one idle edge before each strobe so no strobe is set twice in a step
   task automatic wr(input logic [2:0] a, input logic [15:0] d);
      @(posedge i_sys_clk);
      i_addr <= a;
      i_wdata <= d;
      i_wr <= 1'b1;
      @(posedge i_sys_clk);
      i_wr <= 1'b0;
   endtask
   // read data stand only in the cycle after the strobe
   task automatic rd(input logic [2:0] a, input logic [15:0] exp, input string nm);
      @(posedge i_sys_clk);
      i_addr <= a;
      i_rd <= 1'b1;
      @(posedge i_sys_clk);
      i_rd <= 1'b0;
      #1 chk(nm, exp, o_rdata);
   endtask
   task automatic idle(input int n);
      repeat (n) @(posedge i_sys_clk);
      #1;
   endtask
   task automatic results;
      $display("checks %0d mismatches %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   // watchdog: the tests need well under 200 cycles
   initial begin
      #50000;
      bad_count++;
      results();
   end
   initial begin
      repeat (20) @(posedge i_sys_clk);
      i_rst_n <= 1'b1;
      rd(ADDR_ANALOG_SEL, 16'hffff, "analog_sel");
      rd(ADDR_DIRECTION, RST_DIRECTION, "direction");
      rd(3'h5, 16'h0000, "unmapped");
      @(posedge i_sys_clk);
      ext_en <= 16'hffff;
      ext_val <= 16'ha5a5;
      idle(4);
      rd(ADDR_PIN_LEVEL, 16'h0000, "pin_level");
      chk("analog_en", 16'hffff, o_analog_en);
      chk("periph_in", 16'h0000, o_periph_in);
      $display("test reset_analog done");
      wr(ADDR_ANALOG_SEL, 16'h00ff);
      idle(4);
      rd(ADDR_PIN_LEVEL, 16'ha500, "pin_level");
      chk("periph_in", 16'ha500, o_periph_in);
      chk("analog_en", 16'h00ff, o_analog_en);
      $display("test digital_inputs done");
      ext_en <= 16'h0000;
      wr(ADDR_OUT_LATCH, 16'h1234);
      wr(ADDR_DIRECTION, 16'h0000);
      idle(4);
      chk("oe_n", 16'h0000, o_pin_oe_n);
      chk("pin_out", 16'h1234, o_pin);
      chk("analog_en", 16'h00ff, o_analog_en);
      rd(ADDR_PIN_LEVEL, 16'h1234, "pin_level");
      $display("test outputs done");
      wr(ADDR_OPEN_DRAIN, 16'hffff);
      idle(4);
      chk("oe_n", 16'h1234, o_pin_oe_n);
      chk("pin_out", 16'h0000, o_pin);
      rd(ADDR_PIN_LEVEL, 16'h1234, "pin_level");
      rd(ADDR_OPEN_DRAIN, 16'hffff, "open_drain");
      $display("test open_drain done");
      wr(ADDR_OPEN_DRAIN, 16'h0000);
      i_periph_en <= 16'hffff;
      i_periph_out <= 16'h00ff;
      idle(4);
      rd(ADDR_PIN_LEVEL, 16'h0034, "pin_level");
      $display("test periph_takeover done");
      wr(ADDR_PIN_LEVEL, 16'h5a5a);
      wr(3'h6, 16'hffff);
      idle(4);
      rd(ADDR_OUT_LATCH, 16'h5a5a, "out_latch");
      rd(ADDR_ANALOG_SEL, 16'h00ff, "analog_sel");
      rd(ADDR_DIRECTION, 16'h0000, "direction");
      rd(ADDR_PIN_LEVEL, 16'h005a, "pin_level");
      $display("test latch_alias done");
      results();
   end
endmodule
`default_nettype wire
